/* bench/cpw_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module cpw_partner
    import cpw_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset, // Bench reset
    input wire logic [3:0] timer_clear, // Clear pulses from unit
    input wire logic [3:0] period_clear, // Clear pulses from unit
    output cpw_pkg::cpw_timers_s timers, // Sixteen-bit counts
    output cpw_pkg::cpw_period_s period_timer // Period timers
);
    logic [1:0] pre_q;
    logic [3:0][15:0] tcnt_q;
    logic [3:0][7:0] pcnt_q;
    assign timers = tcnt_q;
    // Tick every 4 clocks, prescale 1:1
    assign period_timer = {pcnt_q, {4{8'h03}}, {4{pre_q == 2'h3}}};
    // No self wrap: the period only holds if the unit clears
    always_ff @(posedge clk)
    begin
        pre_q <= reset ? 2'h0 : pre_q + 2'h1;
        for (int i = 0; i < 4; i++)
        begin
            tcnt_q[i] <= (reset || timer_clear[i]) ? 16'h0 : tcnt_q[i] + 16'h1;
            if (reset || period_clear[i])
                pcnt_q[i] <= 8'h00;
            else if (pre_q == 2'h3)
                pcnt_q[i] <= pcnt_q[i] + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* bench/cpw_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpw_defs.svh"
module cpw_top_bench;
    import cpw_pkg::*;
    logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, adc_trigger_select = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, pin_out, pin_oe, event_pulse, adc_start;
    logic [3:0] timer_clear, period_clear;
    cpw_timers_s timers;
    cpw_period_s period_timer;
    cpw_sources_s sources = '0;
    logic [15:0] capv;
    int fails = 0, checks = 0, cyc = 0, evn = 0, adcn = 0, hin = 0, rises = 0, clrn = 0;
    always #5 clk = ~clk;
    cpw_top cpw_top_i (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(`CPW_HSIZE_WORD), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timers, .period_timer, .sources, .adc_trigger_select,
        .pin_out, .pin_oe, .timer_clear, .period_clear, .event_pulse, .adc_start);
    cpw_partner cpw_partner_i (.clk, .reset, .timer_clear, .period_clear, .timers, .period_timer);
    // Counted on the falling edge so tasks may zero them at the rising edge
    always @(negedge clk)
    begin
        evn <= evn + int'(event_pulse === 1'b1);
        adcn <= adcn + int'(adc_start === 1'b1);
        hin <= hin + int'(pin_out === 1'b1);
        rises <= rises + int'($rose(pin_out));
        clrn <= clrn + int'(timer_clear);
        if (event_pulse === 1'b1) capv <= timers.count[0] - 16'h1;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
        check({hresp, pin_oe}, 2'b00);
        bus(1'b1, `CPW_OFS_CONTROL, 32'hff);
        rchk(`CPW_OFS_CONTROL, 32'h9f);
        bus(1'b1, `CPW_OFS_CAPSRC, 32'hff);
        rchk(`CPW_OFS_CAPSRC, 32'h0f);
        bus(1'b1, `CPW_OFS_CONTROL, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_capture();
        logic [3:0] m [9] = '{4'hc, 4'hd, 4'he, 4'h0, 4'h5, 4'h4, 4'h3, 4'h6, 4'h7};
        int e [9] = '{0, 0, 0, 0, 16, 16, 32, 4, 1};
        bus(1'b1, `CPW_OFS_CAPSRC, 32'h5);
        adc_trigger_select <= 1'b1;
        for (int k = 0; k < 9; k++)
        begin
            bus(1'b1, `CPW_OFS_CONTROL, {24'h0, 4'h8, m[k]});
            evn = 0;
            adcn = 0;
            repeat (16)
            begin
                repeat (3) @(posedge clk);
                sources.logic_cell_output[0] <= 1'b1;
                repeat (3) @(posedge clk);
                sources.logic_cell_output[0] <= 1'b0;
            end
            repeat (4) @(posedge clk);
            check(evn, e[k]);
            check(adcn, e[k]);
        end
        rchk(`CPW_OFS_VAL_LOW, capv[7:0]);
        rchk(`CPW_OFS_VAL_HIGH, capv[15:8]);
        rchk(`CPW_OFS_STATUS, 32'h1);
        bus(1'b1, `CPW_OFS_STATUS, 32'h1);
        rchk(`CPW_OFS_STATUS, 32'h0);
        $display("test capture done");
    endtask
    task automatic t_compare();
        logic [3:0] m [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'ha, 4'hb};
        logic p [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        int r [6] = '{1, 0, 1, 1, 1, 1};
        logic [15:0] v;
        for (int k = 0; k < 6; k++)
        begin
            bus(1'b1, `CPW_OFS_CONTROL, 32'h0);
            bus(1'b1, `CPW_OFS_TIMER_SEL, k % 4);
            v = timers.count[k % 4] + 16'h60;
            bus(1'b1, `CPW_OFS_VAL_LOW, v[7:0]);
            bus(1'b1, `CPW_OFS_VAL_HIGH, v[15:8]);
            bus(1'b1, `CPW_OFS_CONTROL, {24'h0, 4'h8, m[k]});
            rises = 0;
            clrn = 0;
            for (int i = 0; i < 120 && event_pulse !== 1'b1; i++) @(posedge clk);
            repeat (4) @(posedge clk);
            check(pin_out, p[k]);
            check(rises, r[k]);
            check(clrn, (m[k] == 4'h1 || m[k] == 4'hb) ? 1 << (k % 4) : 0);
            rchk(`CPW_OFS_CONTROL, {24'h0, 2'h2, p[k], 1'b0, m[k]});
        end
        $display("test compare done");
    endtask
    task automatic t_pwm();
        logic [7:0] c [5] = '{8'h9f, 8'h9f, 8'h8f, 8'h8f, 8'h8f};
        logic [7:0] h [5] = '{8'h02, 8'h00, 8'hfc, 8'h00, 8'h01};
        logic [7:0] l [5] = '{8'h3f, 8'h80, 8'h08, 8'h00, 8'h00};
        int e [5] = '{32, 8, 32, 0, 64};
        bus(1'b1, `CPW_OFS_TIMER_SEL, 32'h0);
        for (int k = 0; k < 5; k++)
        begin
            bus(1'b1, `CPW_OFS_VAL_LOW, l[k]);
            bus(1'b1, `CPW_OFS_VAL_HIGH, h[k]);
            bus(1'b1, `CPW_OFS_CONTROL, c[k]);
            for (int i = 0; i < 1100 && period_clear[0] !== 1'b1; i++) @(posedge clk);
            repeat (48) @(posedge clk);
            hin = 0;
            repeat (64) @(posedge clk);
            check(hin, e[k]);
        end
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({pin_out, pin_oe}, 2'b00);
        rchk(`CPW_OFS_CONTROL, 32'h0);
        $display("test pwm done");
    endtask
    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_capture();
        t_compare();
        t_pwm();
        stop_test();
    end
endmodule
`default_nettype wire

/* bench/cpw_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cpw_top_properties
    import cpw_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire cpw_pkg::cpw_period_s period_timer, // Period timers
    input wire logic adc_trigger_select, // Trigger source select
    input wire logic pin_out, // Output level
    input wire logic pin_oe, // Output drive
    input wire logic [3:0] timer_clear, // Timer clears
    input wire logic [3:0] period_clear, // Period clears
    input wire logic event_pulse, // Unit event
    input wire logic adc_start // Conversion start
);
    logic [3:0] pmatch;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pmatch[i] = period_timer.tick[i] && (period_timer.count[i] == period_timer.period[i]);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_pin_input: assert property (disable iff (1'b0) reset |=> !pin_oe && !pin_out)
        else $error("pin not released by reset");
    a_reset_pulses_quiet: assert property (disable iff (1'b0) reset |=> !event_pulse && !adc_start
        && timer_clear == 4'h0 && period_clear == 4'h0) else $error("pulse during reset");
    a_adc_start_cause: assert property (adc_start == (event_pulse && $past(adc_trigger_select)))
        else $error("conversion start not tied to event");
    a_timer_clear_onehot: assert property ($onehot0(timer_clear))
        else $error("more than one timer cleared");
    a_clear_with_event: assert property (timer_clear != 4'h0 |-> event_pulse)
        else $error("timer clear without event");
    a_clear_one_cycle: assert property (timer_clear != 4'h0 |=> timer_clear == 4'h0)
        else $error("timer clear longer than one cycle");
    a_period_clear_onehot: assert property ($onehot0(period_clear))
        else $error("more than one period timer cleared");
    a_period_clear_cause: assert property ((period_clear & ~$past(pmatch)) == 4'h0)
        else $error("period clear without period match");
endmodule
bind cpw_top cpw_top_properties cpw_top_properties_i (.clk, .reset, .period_timer, .adc_trigger_select,
    .pin_out, .pin_oe, .timer_clear, .period_clear, .event_pulse, .adc_start);
`default_nettype wire

/* rtl/cpw_ahb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpw_defs.svh"
module cpw_ahb_slave (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic [31:0] rdata, // Read mux from register file
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output cpw_pkg::cpw_reg_req_s req // Register access in data phase
);
    import cpw_pkg::*;

    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    wire addr_take = hsel & hready & htrans[1];
    wire size_ok = (hsize == `CPW_HSIZE_WORD);

    // One wait state on reads so a write just before is already visible
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end
        else
        begin
            wr_pend_q <= addr_take & hwrite & size_ok;
            rd_pend_q <= addr_take & ~hwrite;
            if (addr_take)
                addr_q <= haddr[7:0];
            hreadyout_q <= ~(addr_take & ~hwrite);
            if (rd_pend_q)
                hrdata_q <= rdata;
        end
    end

    assign req = '{wr: wr_pend_q, rd: rd_pend_q, addr: addr_q, wdata: hwdata};
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

/* rtl/cpw_defs.svh */
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH

// Register byte offsets
`define CPW_OFS_CONTROL 8'h00
`define CPW_OFS_CAPSRC 8'h04
`define CPW_OFS_VAL_LOW 8'h08
`define CPW_OFS_VAL_HIGH 8'h0c
`define CPW_OFS_TIMER_SEL 8'h10
`define CPW_OFS_STATUS 8'h14

// Control register fields
`define CPW_CTRL_EN_BIT 7
`define CPW_CTRL_OUT_BIT 5
`define CPW_CTRL_FMT_BIT 4
`define CPW_CTRL_MODE_MSB 3
`define CPW_CTRL_MODE_LSB 0

// Other fields
`define CPW_CAPSRC_MSB 3
`define CPW_TSEL_MSB 1
`define CPW_STATUS_FLAG_BIT 0

// Reset values
`define CPW_RST_CONTROL 8'h00
`define CPW_RST_CAPSRC 4'h0
`define CPW_RST_VALUE 8'h00
`define CPW_RST_TSEL 2'h0

// Capture sources
`define CPW_CAPSRC_LAST 4'h8
`define CPW_CAPSRC_COUNT 9

// Capture prescale terminal counts
`define CPW_PRESCALE4_LAST 4'h3
`define CPW_PRESCALE16_LAST 4'hf

// AHB codes
`define CPW_HSIZE_WORD 3'b010

`endif

/* rtl/cpw_pkg.sv */
package cpw_pkg;

    typedef enum logic [3:0] {
        CPW_MODE_OFF = 4'b0000,
        CPW_MODE_TGL_CLR = 4'b0001,
        CPW_MODE_TGL = 4'b0010,
        CPW_MODE_CAP_ANY = 4'b0011,
        CPW_MODE_CAP_FALL = 4'b0100,
        CPW_MODE_CAP_RISE = 4'b0101,
        CPW_MODE_CAP_RISE4 = 4'b0110,
        CPW_MODE_CAP_RISE16 = 4'b0111,
        CPW_MODE_CMP_SET = 4'b1000,
        CPW_MODE_CMP_CLR = 4'b1001,
        CPW_MODE_CMP_PULSE = 4'b1010,
        CPW_MODE_CMP_PULSE_CLR = 4'b1011,
        CPW_MODE_RSV_C = 4'b1100,
        CPW_MODE_RSV_D = 4'b1101,
        CPW_MODE_RSV_E = 4'b1110,
        CPW_MODE_PWM = 4'b1111
    } cpw_mode_e;

    typedef struct packed {
        logic [3:0][15:0] count;
    } cpw_timers_s;

    typedef struct packed {
        logic [3:0][7:0] count;
        logic [3:0][7:0] period;
        logic [3:0] tick;
    } cpw_period_s;

    typedef struct packed {
        logic [3:0] logic_cell_output;
        logic pin_change_event;
        logic oscillator_output;
        logic comparator_two_output;
        logic comparator_one_output;
        logic pin_mapped_input;
    } cpw_sources_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cpw_reg_req_s;

endpackage

/* rtl/cpw_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cpw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [WIDTH-1:0] async_in, // Inputs from outside the domain
    output logic [WIDTH-1:0] sync_out // Filtered, synchronised copy
);
    logic [WIDTH-1:0] ff1_q;
    logic [WIDTH-1:0] ff2_q;
    logic [WIDTH-1:0] ff3_q;
    logic [WIDTH-1:0] out_q;
    wire [WIDTH-1:0] agree = ~(ff2_q ^ ff3_q);
    // A change is taken only once two settled stages agree
    wire [WIDTH-1:0] out_d = (agree & ff3_q) | (~agree & out_q);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
            out_q <= '0;
        end
        else
        begin
            ff1_q <= async_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule
`default_nettype wire

/* rtl/cpw_top.sv */
// Operation
// - Any reset restores every register and turns the pin to input.
// - PWM timing runs from the system clock and scales with it.
// - Control bit 7 enables the unit; resets to zero.
// - Control read bit shows the live output; writes ignored.
// - Alignment bit picks right (0) or left (1) in PWM only.
// - Mode 1111 is PWM; 1100 to 1110 do nothing.
// - Modes 1010/1011 pulse the output on match; 1011 also clears timer.
// - Mode 1001 drives output low, 1000 high, on match.
// - Mode 0111 captures every 16th rising edge, 0110 every 4th.
// - Modes 0101 rising, 0100 falling, 0011 every edge capture.
// - Mode 0010 toggles on match; 0001 toggles and clears timer.
// - Mode 0000 turns everything off and holds reset condition.
// - Every mode event sets the flag and may start a conversion.
// - Capture source field picks one of nine inputs; rest reserved.
// - Capture loads value bytes from the selected timer.
// - Compare matches the value bytes against the selected timer.
// - Right alignment: low byte is width 7:0, high 1:0 is 9:8.
// - Left alignment: high byte is width 9:2, low 7:6 is 1:0.
// - Width bytes latch into the duty buffer only at period match.
// - After period match clear timer, set pin unless duty is zero.
// - Clear the output when 10-bit time base equals duty.
// - Timer select field chooses one of four time bases.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpw_defs.svh"
module cpw_top (
    input wire logic clk, // System clock, 100 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB ready out
    output logic hresp, // AHB response, OKAY
    input wire cpw_pkg::cpw_timers_s timers, // Four 16-bit timer counts
    input wire cpw_pkg::cpw_period_s period_timer, // Four period timers
    input wire cpw_pkg::cpw_sources_s sources, // Capture sources
    input wire logic adc_trigger_select, // This unit drives the converter trigger
    output logic pin_out, // Output pin level
    output logic pin_oe, // Output pin drive enable
    output logic [3:0] timer_clear, // Clear pulse per 16-bit timer
    output logic [3:0] period_clear, // Clear pulse per period timer
    output logic event_pulse, // One cycle per unit event
    output logic adc_start // Conversion start pulse
);
    import cpw_pkg::*;

    cpw_reg_req_s req;
    logic [31:0] rdata;

    cpw_ahb_slave u_bus (
        .clk(clk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .rdata(rdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .req(req)
    );

    // Pin and comparators are asynchronous; the rest share this clock
    logic [2:0] async_sync;

    cpw_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({sources.comparator_two_output, sources.comparator_one_output, sources.pin_mapped_input}),
        .sync_out(async_sync)
    );

    // Register state
    logic unit_enable_q;
    logic width_alignment_q;
    cpw_mode_e mode_select_q;
    logic [3:0] capture_source_field_q;
    logic [7:0] value_low_byte_q;
    logic [7:0] value_high_byte_q;
    logic [1:0] timer_select_q;
    logic event_flag_q;

    // Engine state
    logic output_state_q;
    logic pin_oe_q;
    logic pulse_q;
    logic cap_prev_q;
    logic [3:0] edge_cnt_q;
    logic cmp_eq_prev_q;
    logic [9:0] duty_q;
    logic [1:0] sub_q;
    logic [3:0] timer_clear_q;
    logic [3:0] period_clear_q;
    logic event_pulse_q;
    logic adc_start_q;

    function automatic logic is_capture(input cpw_mode_e m);
        is_capture = (m == CPW_MODE_CAP_ANY) || (m == CPW_MODE_CAP_FALL) || (m == CPW_MODE_CAP_RISE)
            || (m == CPW_MODE_CAP_RISE4) || (m == CPW_MODE_CAP_RISE16);
    endfunction

    function automatic logic is_compare(input cpw_mode_e m);
        is_compare = (m == CPW_MODE_TGL_CLR) || (m == CPW_MODE_TGL) || (m == CPW_MODE_CMP_SET)
            || (m == CPW_MODE_CMP_CLR) || (m == CPW_MODE_CMP_PULSE) || (m == CPW_MODE_CMP_PULSE_CLR);
    endfunction

    // Places the 10-bit width from the two value bytes
    function automatic logic [9:0] pulse_width(input logic left, input logic [7:0] hi, input logic [7:0] lo);
        pulse_width = left ? {hi, lo[7:6]} : {hi[1:0], lo};
    endfunction

    function automatic logic [3:0] one_hot(input logic [1:0] sel);
        one_hot = 4'h1 << sel;
    endfunction

    // Register decode
    wire wr_ctrl = req.wr && (req.addr == `CPW_OFS_CONTROL);
    wire wr_cap = req.wr && (req.addr == `CPW_OFS_CAPSRC);
    wire wr_low = req.wr && (req.addr == `CPW_OFS_VAL_LOW);
    wire wr_high = req.wr && (req.addr == `CPW_OFS_VAL_HIGH);
    wire wr_tsel = req.wr && (req.addr == `CPW_OFS_TIMER_SEL);
    wire wr_status = req.wr && (req.addr == `CPW_OFS_STATUS);

    // Mode qualifiers; reserved codes fall only in active
    wire active = unit_enable_q && (mode_select_q != CPW_MODE_OFF);
    wire cap_mode = active && is_capture(mode_select_q);
    wire cmp_mode = active && is_compare(mode_select_q);
    wire pwm_mode = active && (mode_select_q == CPW_MODE_PWM);

    // Capture source selection
    wire [`CPW_CAPSRC_COUNT-1:0] src_vec = {sources.logic_cell_output, sources.pin_change_event,
        sources.oscillator_output, async_sync[2], async_sync[1], async_sync[0]};
    wire cap_src_ok = (capture_source_field_q <= `CPW_CAPSRC_LAST);
    wire cap_in = cap_src_ok ? src_vec[capture_source_field_q] : 1'b0;

    // Edge detection and prescaling
    wire cap_rise = cap_in && !cap_prev_q;
    wire cap_fall = !cap_in && cap_prev_q;
    wire hit_any = (mode_select_q == CPW_MODE_CAP_ANY) && (cap_rise || cap_fall);
    wire hit_fall = (mode_select_q == CPW_MODE_CAP_FALL) && cap_fall;
    wire hit_rise = (mode_select_q == CPW_MODE_CAP_RISE) && cap_rise;
    wire hit_rise4 = (mode_select_q == CPW_MODE_CAP_RISE4) && cap_rise
        && (edge_cnt_q[1:0] == 2'(`CPW_PRESCALE4_LAST));
    wire hit_rise16 = (mode_select_q == CPW_MODE_CAP_RISE16) && cap_rise
        && (edge_cnt_q == `CPW_PRESCALE16_LAST);
    wire cap_event = cap_mode && (hit_any || hit_fall || hit_rise || hit_rise4 || hit_rise16);

    // Compare against the selected 16-bit timer
    wire [15:0] sel_timer = timers.count[timer_select_q];
    wire cmp_eq = (sel_timer == {value_high_byte_q, value_low_byte_q});
    // Only the first cycle of equality counts, a stalled timer fires once
    wire cmp_event = cmp_mode && cmp_eq && !cmp_eq_prev_q;
    wire cmp_clears = (mode_select_q == CPW_MODE_TGL_CLR) || (mode_select_q == CPW_MODE_CMP_PULSE_CLR);

    // PWM time base
    wire [7:0] sel_pcount = period_timer.count[timer_select_q];
    wire [7:0] sel_period = period_timer.period[timer_select_q];
    wire sel_tick = period_timer.tick[timer_select_q];
    wire period_match = pwm_mode && sel_tick && (sel_pcount == sel_period);
    wire [9:0] time_base = {sel_pcount, sub_q};
    wire [9:0] new_width = pulse_width(width_alignment_q, value_high_byte_q, value_low_byte_q);
    // Pin is registered, so compare the next count
    wire [9:0] next_base = (|period_clear_q) ? 10'h001 : time_base + 10'h001;
    wire pwm_clr = pwm_mode && (next_base == duty_q);

    wire unit_event = cap_event || cmp_event || period_match;

    // Register file writes
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            unit_enable_q <= 1'(`CPW_RST_CONTROL >> `CPW_CTRL_EN_BIT);
            width_alignment_q <= 1'b0;
            mode_select_q <= CPW_MODE_OFF;
            capture_source_field_q <= `CPW_RST_CAPSRC;
            timer_select_q <= `CPW_RST_TSEL;
        end
        else
        begin
            if (wr_ctrl)
            begin
                unit_enable_q <= req.wdata[`CPW_CTRL_EN_BIT];
                width_alignment_q <= req.wdata[`CPW_CTRL_FMT_BIT];
                mode_select_q <= cpw_mode_e'(req.wdata[`CPW_CTRL_MODE_MSB:`CPW_CTRL_MODE_LSB]);
            end
            if (wr_cap)
                capture_source_field_q <= req.wdata[`CPW_CAPSRC_MSB:0];
            if (wr_tsel)
                timer_select_q <= req.wdata[`CPW_TSEL_MSB:0];
        end
    end

    // Value bytes; a capture beats a software write in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            value_low_byte_q <= `CPW_RST_VALUE;
            value_high_byte_q <= `CPW_RST_VALUE;
        end
        else if (cap_event)
        begin
            value_low_byte_q <= sel_timer[7:0];
            value_high_byte_q <= sel_timer[15:8];
        end
        else
        begin
            if (wr_low)
                value_low_byte_q <= req.wdata[7:0];
            if (wr_high)
                value_high_byte_q <= req.wdata[7:0];
        end
    end

    // Sticky event flag, write one to clear, a new event wins
    always_ff @(posedge clk)
    begin
        if (reset)
            event_flag_q <= 1'b0;
        else
            event_flag_q <= unit_event
                || (event_flag_q && !(wr_status && req.wdata[`CPW_STATUS_FLAG_BIT]));
    end

    // Capture edge tracking; counter restarts while not capturing
    always_ff @(posedge clk)
    begin
        if (reset || !cap_mode || wr_ctrl)
        begin
            cap_prev_q <= cap_in;
            edge_cnt_q <= 4'h0;
        end
        else
        begin
            cap_prev_q <= cap_in;
            if (cap_rise)
                edge_cnt_q <= edge_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            cmp_eq_prev_q <= 1'b0;
        else
            cmp_eq_prev_q <= cmp_eq;
    end

    // Sub-count from the system clock gives the two low time base bits
    always_ff @(posedge clk)
    begin
        if (reset || !pwm_mode || sel_tick)
            sub_q <= 2'h0;
        else
            sub_q <= sub_q + 2'h1;
    end

    // Duty buffer, double buffered for glitch-free updates
    always_ff @(posedge clk)
    begin
        if (reset || !pwm_mode)
            duty_q <= 10'h000;
        else if (period_match)
            duty_q <= new_width;
    end

    // Output engine
    always_ff @(posedge clk)
    begin
        if (reset || !active)
        begin
            output_state_q <= 1'b0;
            pulse_q <= 1'b0;
        end
        else if (pwm_mode)
        begin
            pulse_q <= 1'b0;
            if (period_match)
                output_state_q <= (new_width != 10'h000);
            else if (pwm_clr)
                output_state_q <= 1'b0;
        end
        else if (pulse_q)
        begin
            // The pulse lasts one cycle, then returns low
            output_state_q <= 1'b0;
            pulse_q <= 1'b0;
        end
        else if (cmp_event)
        begin
            unique case (mode_select_q)
                CPW_MODE_TGL, CPW_MODE_TGL_CLR:
                    output_state_q <= !output_state_q;
                CPW_MODE_CMP_SET:
                    output_state_q <= 1'b1;
                CPW_MODE_CMP_CLR:
                    output_state_q <= 1'b0;
                CPW_MODE_CMP_PULSE, CPW_MODE_CMP_PULSE_CLR:
                begin
                    output_state_q <= 1'b1;
                    pulse_q <= 1'b1;
                end
                default:
                    output_state_q <= output_state_q;
            endcase
        end
    end

    // Pin drives only in compare or PWM; input otherwise and at reset
    always_ff @(posedge clk)
    begin
        if (reset)
            pin_oe_q <= 1'b0;
        else
            pin_oe_q <= cmp_mode || pwm_mode;
    end

    // Event side pulses
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            timer_clear_q <= 4'h0;
            period_clear_q <= 4'h0;
            event_pulse_q <= 1'b0;
            adc_start_q <= 1'b0;
        end
        else
        begin
            timer_clear_q <= (cmp_event && cmp_clears) ? one_hot(timer_select_q) : 4'h0;
            period_clear_q <= period_match ? one_hot(timer_select_q) : 4'h0;
            event_pulse_q <= unit_event;
            adc_start_q <= unit_event && adc_trigger_select;
        end
    end

    // Read mux; bit 6 reads zero, bit 5 is the live output
    wire [7:0] ctrl_rd = {unit_enable_q, 1'b0, output_state_q, width_alignment_q, mode_select_q};
    assign rdata = (req.addr == `CPW_OFS_CONTROL) ? {24'h000000, ctrl_rd} :
        (req.addr == `CPW_OFS_CAPSRC) ? {28'h0000000, capture_source_field_q} :
        (req.addr == `CPW_OFS_VAL_LOW) ? {24'h000000, value_low_byte_q} :
        (req.addr == `CPW_OFS_VAL_HIGH) ? {24'h000000, value_high_byte_q} :
        (req.addr == `CPW_OFS_TIMER_SEL) ? {30'h00000000, timer_select_q} :
        (req.addr == `CPW_OFS_STATUS) ? {31'h00000000, event_flag_q} :
        32'h0000_0000;

    assign pin_out = output_state_q;
    assign pin_oe = pin_oe_q;
    assign timer_clear = timer_clear_q;
    assign period_clear = period_clear_q;
    assign event_pulse = event_pulse_q;
    assign adc_start = adc_start_q;
endmodule
`default_nettype wire
